// ### src/pll_clock_resync_cfg.svh
`ifndef PLL_CLOCK_RESYNC_CFG_SVH
`define PLL_CLOCK_RESYNC_CFG_SVH

// Register offsets.
`define OFS_REF_PIN_SELECT      8'h12
`define OFS_RESYNC_CONTROL      8'h13
`define OFS_PRE_DIVIDER         8'h14
`define OFS_INT_MULTIPLIER      8'h15
`define OFS_FRACTION_UPPER      8'h16

// Reset values.
`define RST_REF_PIN_SELECT      8'h00
`define RST_RESYNC_CONTROL      8'h10
`define RST_PRE_DIVIDER         8'h01
`define RST_INT_MULTIPLIER      8'h08
`define RST_FRACTION_UPPER      8'h00

// Field positions.
`define REF_PIN_CHOICE_MSB      2
`define REF_PIN_CHOICE_LSB      0
`define AUTO_REALIGN_ON_BIT     4
`define MANUAL_REALIGN_REQ_BIT  0
`define PRE_DIV_MSB             6
`define PRE_DIV_LSB             3
`define INT_MULT_MSB            5
`define INT_MULT_LSB            0
`define FRAC_UPPER_MSB          5
`define FRAC_UPPER_LSB          0

// Pin choice codes.
`define REF_PIN_CODE_ZERO       3'h3
`define REF_PIN_CODE_TWO        3'h5

`endif

// ### src/pll_clock_resync_pkg.sv
`default_nettype none
package pll_clock_resync_pkg;

  typedef enum logic [3:0] {
    ST_RUN    = 4'h1,
    ST_HALT   = 4'h2,
    ST_RESUME = 4'h4,
    ST_AUTO   = 4'h8
  } align_state_t;

endpackage
`default_nettype wire

// ### src/pll_clock_resync_config.sv
// Operation
// [R01] Pin choice code 011 picks pin zero, 101 pin two, others mute.
// [R02] Auto realign bit 4 resets to one; writing zero disables it.
// [R03] With auto realign on, realign clocks just before leaving standby.
// [R04] Manual request one halts converter, pump and oversampling clocks by reset.
// [R05] Clearing the request restarts the clocks at the next frame start.
// [R06] Pre-divider bits 6..3 give factor code plus one; host avoids 1111.
// [R07] Integer multiplier code is J directly; host avoids code zero.
// [R08] Bits 5..0 are upper fraction part; host keeps D at most 9999.
// [R09] In automatic clock setup the programmed P, J, D are ignored.
// [R10] Post multiplier factor is the 4-bit code plus one.
// [R11] Host writes reserved bits with reset values, changes PLL while idle.
`timescale 1ns/1ps
`default_nettype none
`include "pll_clock_resync_cfg.svh"

module pll_clock_resync_config (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData_r,
  output logic            regRdValid_r,
  input  wire logic       frameStart,
  input  wire logic       standbyExitReq,
  input  wire logic       autoClockSetup,
  input  wire logic [3:0] autoPreDivCode,
  input  wire logic [5:0] autoIntMult,
  input  wire logic [5:0] autoFracUpper,
  input  wire logic [3:0] pllPostMultCode,
  input  wire logic [3:0] autoPostMultCode,
  output logic            refPinZeroSel_r,
  output logic            refPinTwoSel_r,
  output logic            refMuted_r,
  output logic            audioClkHalt_r,
  output logic            normalOpGo_r,
  output logic      [4:0] preDivFactor_r,
  output logic      [5:0] intMult_r,
  output logic      [5:0] fracUpper_r,
  output logic      [4:0] postMultFactor_r
);

  logic [7:0] refSel_r;
  logic [7:0] refSel_nxt;
  logic [7:0] resyncCtl_r;
  logic [7:0] resyncCtl_nxt;
  logic [7:0] preDiv_r;
  logic [7:0] preDiv_nxt;
  logic [7:0] intMultReg_r;
  logic [7:0] intMultReg_nxt;
  logic [7:0] fracReg_r;
  logic [7:0] fracReg_nxt;
  logic [7:0] rdData_nxt;
  logic       rdValid_nxt;

  always_comb begin
    refSel_nxt     = refSel_r;
    resyncCtl_nxt  = resyncCtl_r;
    preDiv_nxt     = preDiv_r;
    intMultReg_nxt = intMultReg_r;
    fracReg_nxt    = fracReg_r;
    rdValid_nxt    = regRdEn;
    rdData_nxt     = regRdData_r;
    if (regWrEn) begin
      unique case (regAddr)
        `OFS_REF_PIN_SELECT: refSel_nxt = regWrData;
        `OFS_RESYNC_CONTROL: resyncCtl_nxt = regWrData;
        `OFS_PRE_DIVIDER:    preDiv_nxt = regWrData;
        `OFS_INT_MULTIPLIER: intMultReg_nxt = regWrData;
        `OFS_FRACTION_UPPER: fracReg_nxt = regWrData;
        default: ;
      endcase
    end
    if (regRdEn) begin
      unique case (regAddr)
        `OFS_REF_PIN_SELECT: rdData_nxt = refSel_r;
        `OFS_RESYNC_CONTROL: rdData_nxt = resyncCtl_r;
        `OFS_PRE_DIVIDER:    rdData_nxt = preDiv_r;
        `OFS_INT_MULTIPLIER: rdData_nxt = intMultReg_r;
        `OFS_FRACTION_UPPER: rdData_nxt = fracReg_r;
        default:             rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      refSel_r     <= `RST_REF_PIN_SELECT;
      // [R02] auto realign default
      resyncCtl_r  <= `RST_RESYNC_CONTROL;
      preDiv_r     <= `RST_PRE_DIVIDER;
      intMultReg_r <= `RST_INT_MULTIPLIER;
      fracReg_r    <= `RST_FRACTION_UPPER;
      regRdData_r  <= 8'h00;
      regRdValid_r <= 1'b0;
    end else begin
      refSel_r     <= refSel_nxt;
      resyncCtl_r  <= resyncCtl_nxt;
      preDiv_r     <= preDiv_nxt;
      intMultReg_r <= intMultReg_nxt;
      fracReg_r    <= fracReg_nxt;
      regRdData_r  <= rdData_nxt;
      regRdValid_r <= rdValid_nxt;
    end
  end

  logic [2:0] refPinChoice;
  logic       autoRealignOn;
  logic       manualRealignRequest;
  logic       zeroSel_nxt;
  logic       twoSel_nxt;
  logic       muted_nxt;
  logic [4:0] preDivFactor_nxt;
  logic [5:0] intMult_nxt;
  logic [5:0] fracUpper_nxt;
  logic [4:0] postMult_nxt;

  assign refPinChoice         = refSel_r[`REF_PIN_CHOICE_MSB:`REF_PIN_CHOICE_LSB];
  assign autoRealignOn        = resyncCtl_r[`AUTO_REALIGN_ON_BIT];
  assign manualRealignRequest = resyncCtl_r[`MANUAL_REALIGN_REQ_BIT];

  always_comb begin
    // [R01] reference pin decode
    zeroSel_nxt = (refPinChoice == `REF_PIN_CODE_ZERO);
    twoSel_nxt  = (refPinChoice == `REF_PIN_CODE_TWO);
    muted_nxt   = !(zeroSel_nxt || twoSel_nxt);
    // [R09] automatic setup override
    if (autoClockSetup) begin
      // [R06] factor is code plus one
      preDivFactor_nxt = {1'b0, autoPreDivCode} + 5'h01;
      // [R07] J taken directly
      intMult_nxt      = autoIntMult;
      // [R08] upper fraction part
      fracUpper_nxt    = autoFracUpper;
      // [R10] post factor code plus one
      postMult_nxt     = {1'b0, autoPostMultCode} + 5'h01;
    end else begin
      // [R06] factor is code plus one
      preDivFactor_nxt = {1'b0, preDiv_r[`PRE_DIV_MSB:`PRE_DIV_LSB]} + 5'h01;
      // [R07] J taken directly
      intMult_nxt      = intMultReg_r[`INT_MULT_MSB:`INT_MULT_LSB];
      // [R08] upper fraction part
      fracUpper_nxt    = fracReg_r[`FRAC_UPPER_MSB:`FRAC_UPPER_LSB];
      // [R10] post factor code plus one
      postMult_nxt     = {1'b0, pllPostMultCode} + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      refPinZeroSel_r  <= 1'b0;
      refPinTwoSel_r   <= 1'b0;
      refMuted_r       <= 1'b1;
      preDivFactor_r   <= 5'h01;
      intMult_r        <= 6'h00;
      fracUpper_r      <= 6'h00;
      postMultFactor_r <= 5'h01;
    end else begin
      refPinZeroSel_r  <= zeroSel_nxt;
      refPinTwoSel_r   <= twoSel_nxt;
      refMuted_r       <= muted_nxt;
      preDivFactor_r   <= preDivFactor_nxt;
      intMult_r        <= intMult_nxt;
      fracUpper_r      <= fracUpper_nxt;
      postMultFactor_r <= postMult_nxt;
    end
  end

  // Realignment sequencer: the three audio clocks are held in synchronous
  // reset while halted and released on a frame start.
  pll_clock_resync_pkg::align_state_t state_r;
  pll_clock_resync_pkg::align_state_t state_nxt;
  logic halt_nxt;
  logic go_nxt;

  always_comb begin
    state_nxt = state_r;
    go_nxt    = 1'b0;
    unique case (state_r)
      pll_clock_resync_pkg::ST_RUN: begin
        // [R04] manual halt
        if (manualRealignRequest) begin
          state_nxt = pll_clock_resync_pkg::ST_HALT;
        // [R03] realign before normal mode
        end else if (standbyExitReq && autoRealignOn) begin
          state_nxt = pll_clock_resync_pkg::ST_AUTO;
        end else if (standbyExitReq) begin
          go_nxt = 1'b1;
        end
      end
      pll_clock_resync_pkg::ST_HALT: begin
        // [R05] wait for request clear
        if (!manualRealignRequest) begin
          state_nxt = pll_clock_resync_pkg::ST_RESUME;
        end
      end
      pll_clock_resync_pkg::ST_RESUME: begin
        if (manualRealignRequest) begin
          state_nxt = pll_clock_resync_pkg::ST_HALT;
        // [R05] resume at frame start
        end else if (frameStart) begin
          state_nxt = pll_clock_resync_pkg::ST_RUN;
        end
      end
      pll_clock_resync_pkg::ST_AUTO: begin
        // [R03] release at frame start
        if (frameStart) begin
          state_nxt = pll_clock_resync_pkg::ST_RUN;
          go_nxt    = 1'b1;
        end
      end
    endcase
    halt_nxt = (state_nxt != pll_clock_resync_pkg::ST_RUN);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r        <= pll_clock_resync_pkg::ST_RUN;
      audioClkHalt_r <= 1'b0;
      normalOpGo_r   <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      audioClkHalt_r <= halt_nxt;
      normalOpGo_r   <= go_nxt;
    end
  end

endmodule

`default_nettype wire

// ### verification/pll_clock_resync_config_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pll_clock_resync_config_sva (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       regWrEn,
  input wire logic       frameStart,
  input wire logic       standbyExitReq,
  input wire logic       autoClockSetup,
  input wire logic       refPinZeroSel_r,
  input wire logic       refMuted_r,
  input wire logic       audioClkHalt_r,
  input wire logic       normalOpGo_r,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [3:0] autoPreDivCode,
  input wire logic [4:0] preDivFactor_r,
  input wire logic [5:0] intMult_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_pin_zero: assert property (regWrEn && regAddr == 8'h12 && regWrData[2:0] == 3'h3
    |-> ##2 refPinZeroSel_r) else $error("pin zero not chosen");
  a_pin_mute: assert property (regWrEn && regAddr == 8'h12 && regWrData[2:0] == 3'h2
    |-> ##2 refMuted_r) else $error("code not muted");
  a_manual_halt: assert property (regWrEn && regAddr == 8'h13 && regWrData[0]
    |-> ##[2:3] audioClkHalt_r) else $error("no halt");
  a_resume_frame: assert property ($fell(audioClkHalt_r) && $past(nrst)
    |-> $past(frameStart)) else $error("resume off frame");
  a_go_cause: assert property (normalOpGo_r && $past(nrst)
    |-> $past(frameStart) || $past(standbyExitReq)) else $error("stray go");
  a_auto_ignore: assert property (autoClockSetup && $past(nrst)
    ##1 autoClockSetup && $stable(autoPreDivCode)
    |-> preDivFactor_r == {1'b0, autoPreDivCode} + 5'h01) else $error("auto P unused");
  a_prog_div: assert property (regWrEn && regAddr == 8'h14 && !autoClockSetup
    ##1 !autoClockSetup [*2] |-> preDivFactor_r == {1'b0, $past(regWrData[6:3], 2)} + 5'h01)
    else $error("P wrong");
  a_prog_int: assert property (regWrEn && regAddr == 8'h15 && !autoClockSetup
    ##1 !autoClockSetup [*2] |-> intMult_r == $past(regWrData[5:0], 2)) else $error("J wrong");
  c_resume: cover property ($fell(audioClkHalt_r));
  c_go: cover property (normalOpGo_r && !audioClkHalt_r);
  c_auto: cover property (autoClockSetup && refMuted_r);
endmodule
bind pll_clock_resync_config pll_clock_resync_config_sva u_sva (
  .clk            (clk),
  .nrst           (nrst),
  .regWrEn        (regWrEn),
  .frameStart     (frameStart),
  .standbyExitReq (standbyExitReq),
  .autoClockSetup (autoClockSetup),
  .refPinZeroSel_r(refPinZeroSel_r),
  .refMuted_r     (refMuted_r),
  .audioClkHalt_r (audioClkHalt_r),
  .normalOpGo_r   (normalOpGo_r),
  .regAddr        (regAddr),
  .regWrData      (regWrData),
  .autoPreDivCode (autoPreDivCode),
  .preDivFactor_r (preDivFactor_r),
  .intMult_r      (intMult_r)
);
`default_nettype wire

// ### verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic       regRdValid_r,
  input  wire logic [7:0] regRdData_r,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData
);
  initial begin
    regWrEn = 1'b0; regRdEn = 1'b0; regAddr = 8'hFF; regWrData = 8'h00;
  end
  // Callers pass legal codes and reset-valued reserved bits.
  // Released lines show the inverse so stale values never look valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin regWrEn <= 1'b1; regAddr <= a; regWrData <= d; end
    @(posedge clk) begin regWrEn <= 1'b0; regAddr <= ~a; regWrData <= ~d; end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk) begin regRdEn <= 1'b1; regAddr <= a; end
    @(posedge clk) begin regRdEn <= 1'b0; regAddr <= ~a; end
    #1;
    d = regRdData_r;
    v = regRdValid_r;
  endtask
endmodule
`default_nettype wire

// ### verification/pll_clock_resync_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module pll_clock_resync_config_tb_top;
  logic       clk, nrst, regWrEn, regRdEn, frameStart, standbyExitReq, autoClockSetup;
  logic       regRdValid_r, refPinZeroSel_r, refPinTwoSel_r, refMuted_r, audioClkHalt_r;
  logic       normalOpGo_r;
  logic [7:0] regAddr, regWrData, regRdData_r, d;
  logic [3:0] autoPreDivCode, pllPostMultCode, autoPostMultCode;
  logic [5:0] autoIntMult, autoFracUpper, intMult_r, fracUpper_r;
  logic [4:0] preDivFactor_r, postMultFactor_r;
  logic [2:0] e;
  logic       v;
  int         fail_count = 0;
  int         total_checks = 0;
  pll_clock_resync_config u_dut (.*);
  host_model u_host (.*);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic frame();
    @(posedge clk) frameStart <= 1'b1;
    @(posedge clk) frameStart <= 1'b0;
    #1;
  endtask
  task automatic leave_standby();
    @(posedge clk) standbyExitReq <= 1'b1;
    @(posedge clk) standbyExitReq <= 1'b0;
    #1;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic s_reset();
    logic [7:0] ex [6];
    ex = '{8'h00, 8'h10, 8'h01, 8'h08, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      u_host.rd(8'h12 + 8'(i), d, v);
      `CHK(v, 1'b1) // read answered.
      `CHK(d, ex[i]) // reset value.
    end
  endtask
  task automatic s_pin();
    for (int c = 0; c < 8; c++) begin
      u_host.wr(8'h12, 8'(c));
      settle(2);
      e = (c == 3) ? 3'b100 : (c == 5) ? 3'b010 : 3'b001;
      `CHK({refPinZeroSel_r, refPinTwoSel_r, refMuted_r}, e) // pin choice.
    end
  endtask
  task automatic s_manual();
    u_host.wr(8'h13, 8'h11);
    settle(3);
    `CHK(audioClkHalt_r, 1'b1) // clocks halted.
    frame();
    `CHK(audioClkHalt_r, 1'b1) // held while requested.
    u_host.wr(8'h13, 8'h10);
    settle(3);
    `CHK(audioClkHalt_r, 1'b1) // waits for frame.
    u_host.wr(8'h13, 8'h11);
    settle(1);
    frame();
    `CHK(audioClkHalt_r, 1'b1) // request again halts.
    u_host.wr(8'h13, 8'h10);
    settle(2);
    frame();
    `CHK(audioClkHalt_r, 1'b0) // resumed on frame.
  endtask
  task automatic s_exit();
    leave_standby();
    `CHK(audioClkHalt_r, 1'b1) // realign first.
    frame();
    `CHK({audioClkHalt_r, normalOpGo_r}, 2'b01) // go at frame.
    u_host.wr(8'h13, 8'h00);
    settle(1);
    leave_standby();
    `CHK({audioClkHalt_r, normalOpGo_r}, 2'b01) // no realign when off.
  endtask
  task automatic s_pll();
    u_host.wr(8'h14, 8'h71);
    u_host.wr(8'h15, 8'h3F);
    u_host.wr(8'h16, 8'h27);
    settle(2);
    `CHK(preDivFactor_r, 5'h0F) // divide by fifteen.
    `CHK(intMult_r, 6'h3F) // J of 63.
    `CHK(fracUpper_r, 6'h27) // upper fraction.
    `CHK(postMultFactor_r, 5'h10) // R of 16.
    u_host.rd(8'h14, d, v);
    `CHK(v, 1'b1) // read answered.
    `CHK(d, 8'h71) // stored as written.
    @(posedge clk) autoClockSetup <= 1'b1;
    settle(2);
    `CHK({preDivFactor_r, intMult_r}, {5'h03, 6'h05}) // auto P and J.
    `CHK({fracUpper_r, postMultFactor_r}, {6'h11, 5'h07}) // auto D and R.
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0; frameStart = 1'b0; standbyExitReq = 1'b0; autoClockSetup = 1'b0;
    autoPreDivCode = 4'h2; autoIntMult = 6'h05; autoFracUpper = 6'h11;
    pllPostMultCode = 4'hF; autoPostMultCode = 4'h6;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    s_reset();
    s_pin();
    s_manual();
    s_exit();
    s_pll();
    end_of_test();
  end
endmodule
`default_nettype wire
